// ===== inc/eeprom_regs.svh
// constants of the three-wire serial eeprom port
// assumes a 20 MHz system clock; included by the port module
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define EE_WORD_W 16
`define EE_WORDS_PER_KBIT 64
`define EE_KBITS_DEF 1
`define EE_ADDR_W_1K 6
`define EE_ADDR_W_BIG 8
`define EE_OP_W 2
`define EE_OP_READ 2'h2
`define EE_OP_WRITE 2'h1
`define EE_OP_ERASE 2'h3
`define EE_OP_SPECIAL 2'h0
`define EE_SP_ENABLE 2'h3
`define EE_SP_ERASE_ALL 2'h2
`define EE_SP_WRITE_ALL 2'h1
`define EE_SP_DISABLE 2'h0
`define EE_ERASED_WORD 16'hFFFF
`define EE_CLK_HZ 20000000
`define EE_MS_DIV 1000
`define EE_PROG_TIME_MS 10
`define EE_FIFO_DEPTH 16
`endif

// ===== inc/eeprom_pkg.sv
// types shared by the serial eeprom port
// assumes eeprom_regs.svh on the include path
package eeprom_pkg;
  // gray codes along start, opcode, address, data, hold
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_HOLD = 3'h6,
    ST_READ = 3'h4
  } state_type;
  // bit 1: whole array, bit 0: erase pattern
  typedef enum logic [1:0] {
    PG_WORD = 2'h0,
    PG_ERASE = 2'h1,
    PG_WRITE_ALL = 2'h2,
    PG_ERASE_ALL = 2'h3
  } prog_type;
endpackage

// ===== inc/fifo_if.sv
// stream carrier between the port logic and its read-ahead fifo
// assumes both ends share one clock
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 16) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic flush;
  modport fifo_side(input in_valid, in_data, out_ready, flush,
                    output in_ready, out_valid, out_data);
  modport user_side(output in_valid, in_data, out_ready, flush,
                    input in_ready, out_valid, out_data);
endinterface

// ===== rtl/data_fifo.sv
// word fifo with a registered output stage and synchronous flush
// assumes DEPTH is a power of two and one clock for both sides
`timescale 1ns/1ns
module data_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  fifo_if.fifo_side bus // stream in and out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic [W-1:0] out_q;
  logic ov_q;
  wire push = bus.in_valid && bus.in_ready;
  wire load = (count_q != '0) && (!ov_q || bus.out_ready);
  assign bus.in_ready = count_q != CW'(DEPTH);
  assign bus.out_valid = ov_q;
  assign bus.out_data = out_q;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wptr_q] <= bus.in_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || bus.flush) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      ov_q <= 1'b0;
      out_q <= '0;
    end else begin
      wptr_q <= wptr_q + PW'(push);
      rptr_q <= rptr_q + PW'(load);
      count_q <= count_q + CW'(push) - CW'(load);
      if (load) begin
        out_q <= mem_q[rptr_q];
        ov_q <= 1'b1;
      end else if (bus.out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    count_q <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// ===== rtl/eeprom_serial_port.sv
// three-wire serial eeprom port: command decode, array, read stream, programming timer
// assumes cs, sk and di come from pins outside clk_i's domain
// Overview of operation
// RULE1: array holds one, two or four kilobits, chosen by parameter KBITS.
// RULE2: every address holds one sixteen-bit word, moved whole.
// RULE3: commands arrive on di clocked by sk, framed by cs; answers leave on do.
// RULE4: reads keep streaming following words while cs stays high.
// RULE5: word or whole-array writes overwrite directly, no separate erase needed.
// RULE6: programming is self-timed and ends within ten milliseconds.
// RULE7: after programming command, status shows on do until next start bit.
// RULE8: do is driven only while cs is high, otherwise released.
// RULE9: first one on di after cs rises is the start bit.
// RULE10: two-bit opcode; opcode zero uses top address bits as sub-command.
// RULE11: writes ignored until enable command; disable restores that; reads always work.
// RULE12: programming starts when cs falls after the command; busy refuses commands.
// RULE13: busy shows as do low, ready as do high.
`include "eeprom_regs.svh"
`timescale 1ns/1ns
module eeprom_serial_port import eeprom_pkg::*; #(
  parameter int KBITS = `EE_KBITS_DEF,
  parameter int PROG_CYC = `EE_PROG_TIME_MS * (`EE_CLK_HZ / `EE_MS_DIV),
  parameter int FIFO_DEPTH = `EE_FIFO_DEPTH
) (
  input wire logic clk_i, // system clock, 20 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cs_i, // chip select pin
  input wire logic sk_i, // serial clock pin
  input wire logic di_i, // serial data in pin
  output logic do_o, // serial data out pin value
  output logic do_oe_o, // serial data out drive enable
  output logic busy_o // programming cycle running
);
  localparam int ADDR_W = (KBITS == 1) ? `EE_ADDR_W_1K : `EE_ADDR_W_BIG;
  localparam int WORDS = KBITS * `EE_WORDS_PER_KBIT; // [RULE1]
  localparam int AI_W = $clog2(WORDS);
  localparam int PCW = $clog2(PROG_CYC + 1);
  localparam int WW = `EE_WORD_W;

  function automatic logic [AI_W-1:0] next_word(input logic [AI_W-1:0] a);
    next_word = (a == AI_W'(WORDS - 1)) ? '0 : a + AI_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] cs_s_q;
  logic [1:0] sk_s_q;
  logic [1:0] di_s_q;
  logic sk_prev_q;
  logic cs_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_s_q <= 2'h0;
      sk_s_q <= 2'h0;
      di_s_q <= 2'h0;
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[0], cs_i};
      sk_s_q <= {sk_s_q[0], sk_i};
      di_s_q <= {di_s_q[0], di_i};
      sk_prev_q <= sk_s_q[1];
      cs_prev_q <= cs_s_q[1];
    end
  end
  wire cs_on = cs_s_q[1];
  wire di_s = di_s_q[1];
  wire sk_rise = cs_on && sk_s_q[1] && !sk_prev_q; // [RULE3]
  wire cs_fall = cs_prev_q && !cs_on;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  state_type st_q;
  logic [4:0] cnt_q;
  logic [`EE_OP_W-1:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [WW-1:0] sh_q;
  logic en_q;
  logic arm_q;
  prog_type pk_q;
  logic [3:0] rbit_q;
  logic [WW-1:0] ser_q;
  logic rdo_q;
  logic busy_q;
  logic status_q;
  fifo_if #(.W(WW)) rd_fifo ();

  wire start_bit = sk_rise && (st_q == ST_IDLE) && di_s && !busy_q; // [RULE9] [RULE12]
  wire opc_last = cnt_q == 5'h1;
  wire addr_last = cnt_q == 5'(ADDR_W - 1);
  wire data_last = cnt_q == 5'(WW - 1);
  wire [ADDR_W-1:0] addr_full = {addr_q[ADDR_W-2:0], di_s};
  wire [1:0] sp_code = addr_full[ADDR_W-1 -: 2];
  wire addr_done = sk_rise && (st_q == ST_ADDR) && addr_last;
  wire is_read = op_q == `EE_OP_READ;
  wire is_write = (op_q == `EE_OP_WRITE) || (op_q == `EE_OP_SPECIAL && sp_code == `EE_SP_WRITE_ALL);
  wire is_erase = (op_q == `EE_OP_ERASE) || (op_q == `EE_OP_SPECIAL && sp_code == `EE_SP_ERASE_ALL);
  wire is_enable = op_q == `EE_OP_SPECIAL && sp_code == `EE_SP_ENABLE;
  wire is_disable = op_q == `EE_OP_SPECIAL && sp_code == `EE_SP_DISABLE;
  wire whole = op_q == `EE_OP_SPECIAL;
  wire pop = sk_rise && (st_q == ST_READ) && (rbit_q == 4'h0) && rd_fifo.out_valid;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h0;
      op_q <= 2'h0;
      addr_q <= '0;
      sh_q <= '0;
      en_q <= 1'b0; // [RULE11]
      arm_q <= 1'b0;
      pk_q <= PG_WORD;
      rbit_q <= 4'h0;
      ser_q <= '0;
      rdo_q <= 1'b0;
    end else if (!cs_on) begin
      st_q <= ST_IDLE;
      arm_q <= 1'b0;
    end else if (sk_rise) begin
      cnt_q <= cnt_q + 5'h1;
      unique case (st_q)
        ST_IDLE: begin
          cnt_q <= 5'h0;
          if (start_bit) begin
            st_q <= ST_OPC;
          end
        end
        ST_OPC: begin
          op_q <= {op_q[0], di_s}; // [RULE10]
          if (opc_last) begin
            st_q <= ST_ADDR;
            cnt_q <= 5'h0;
          end
        end
        ST_ADDR: begin
          addr_q <= addr_full;
          if (addr_last) begin
            cnt_q <= 5'h0;
            pk_q <= prog_type'({whole, is_erase});
            rdo_q <= 1'b0;
            rbit_q <= 4'h0;
            st_q <= is_read ? ST_READ : (is_write ? ST_DATA : ST_HOLD);
            arm_q <= is_erase && en_q; // [RULE11] [RULE5]
            if (is_enable) begin
              en_q <= 1'b1; // [RULE11]
            end else if (is_disable) begin
              en_q <= 1'b0; // [RULE11]
            end
          end
        end
        ST_DATA: begin
          sh_q <= {sh_q[WW-2:0], di_s}; // [RULE2]
          if (data_last) begin
            st_q <= ST_HOLD;
            arm_q <= en_q; // [RULE11]
          end
        end
        ST_HOLD: begin
          arm_q <= 1'b0; // extra clocks cancel programming
        end
        ST_READ: begin
          if (rbit_q == 4'h0) begin
            if (rd_fifo.out_valid) begin
              rdo_q <= rd_fifo.out_data[WW-1];
              ser_q <= {rd_fifo.out_data[WW-2:0], 1'b0};
              rbit_q <= 4'(WW - 1);
            end
          end else begin
            rdo_q <= ser_q[WW-1];
            ser_q <= {ser_q[WW-2:0], 1'b0};
            rbit_q <= rbit_q - 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array and read-ahead
  // ----------------------------------------------------------------
  logic [WW-1:0] mem_q [WORDS];
  logic [WW-1:0] rd_q;
  logic rdv_q;
  logic [AI_W-1:0] pf_addr_q;
  logic sw_act_q;
  logic [AI_W-1:0] sw_addr_q;
  logic [AI_W-1:0] sw_last_q;
  logic [WW-1:0] pg_data_q;
  wire issue = (st_q == ST_READ) && !rdv_q && rd_fifo.in_ready;
  assign rd_fifo.in_valid = rdv_q;
  assign rd_fifo.in_data = rd_q;
  assign rd_fifo.out_ready = pop;
  assign rd_fifo.flush = st_q != ST_READ;

  always_ff @(posedge clk_i) begin
    rd_q <= mem_q[pf_addr_q];
    if (sw_act_q) begin
      mem_q[sw_addr_q] <= pg_data_q; // [RULE5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || st_q != ST_READ) begin
      rdv_q <= 1'b0;
      pf_addr_q <= addr_full[AI_W-1:0];
    end else begin
      rdv_q <= issue;
      if (issue) begin
        pf_addr_q <= next_word(pf_addr_q); // [RULE4]
      end
    end
  end

  data_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(rd_fifo)
  );

  // ----------------------------------------------------------------
  // self-timed programming and status
  // ----------------------------------------------------------------
  logic [PCW-1:0] pcnt_q;
  wire start_pg = cs_fall && arm_q && !busy_q; // [RULE12]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      pcnt_q <= '0;
      sw_act_q <= 1'b0;
      sw_addr_q <= '0;
      sw_last_q <= '0;
      pg_data_q <= '0;
      status_q <= 1'b0;
    end else begin
      if (start_pg) begin
        busy_q <= 1'b1;
        pcnt_q <= PCW'(PROG_CYC - 1); // [RULE6]
        sw_act_q <= 1'b1;
        sw_addr_q <= pk_q[1] ? '0 : addr_q[AI_W-1:0];
        sw_last_q <= pk_q[1] ? AI_W'(WORDS - 1) : addr_q[AI_W-1:0];
        pg_data_q <= pk_q[0] ? `EE_ERASED_WORD : sh_q; // [RULE5]
      end else begin
        if (busy_q) begin
          busy_q <= pcnt_q != '0;
          pcnt_q <= pcnt_q - PCW'(busy_q);
        end
        if (sw_act_q) begin
          sw_act_q <= sw_addr_q != sw_last_q;
          sw_addr_q <= next_word(sw_addr_q);
        end
      end
      if (start_pg) begin
        status_q <= 1'b1; // [RULE7]
      end else if (start_bit) begin
        status_q <= 1'b0; // [RULE7]
      end
    end
  end

  // do is a flop; released one clock after cs is seen low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      do_o <= 1'b0;
      do_oe_o <= 1'b0;
    end else begin
      do_o <= (st_q == ST_READ) ? rdo_q : !busy_q; // [RULE13]
      do_oe_o <= cs_on && (st_q == ST_READ || (st_q == ST_IDLE && status_q)); // [RULE8]
    end
  end
  assign busy_o = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  int hcnt_q;
  always_ff @(posedge clk_i) begin
    hcnt_q <= (rst_i || !busy_q) ? 0 : hcnt_q + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_do_release_low: assert property (!cs_on |=> !do_oe_o) // [RULE8]
    else $error("do driven with cs low");
  a_busy_drives_low: assert property ((status_q && busy_q && cs_on && st_q == ST_IDLE)
    |=> do_oe_o && !do_o) // [RULE13]
    else $error("busy status not low");
  a_prog_cycle_len: assert property ($fell(busy_q) |-> hcnt_q == PROG_CYC) // [RULE6]
    else $error("programming length wrong");
  a_prog_needs_enable: assert property ($rose(busy_q) |-> $past(en_q, 2)) // [RULE11]
    else $error("programming while disabled");
  a_prog_on_cs_fall: assert property ($rose(busy_q) |-> $past(cs_fall)) // [RULE12]
    else $error("programming not started by cs fall");
  a_busy_no_command: assert property ((busy_q && st_q == ST_IDLE) |=> st_q == ST_IDLE) // [RULE12]
    else $error("command taken while busy");
  a_start_clears_stat: assert property (start_bit |=> !status_q && st_q == ST_OPC) // [RULE7]
    else $error("start bit handling wrong");
  a_erase_pattern: assert property ((sw_act_q && pk_q[0]) |-> pg_data_q == `EE_ERASED_WORD)
    else $error("erase pattern wrong"); // [RULE5]
  a_read_increment: assert property (issue |=> pf_addr_q == next_word($past(pf_addr_q)))
    else $error("read address not advanced"); // [RULE4]
  a_enable_cmd: assert property ((addr_done && is_enable) |=> en_q) // [RULE11]
    else $error("enable not taken");
  c_read_word: cover property (pop);
  c_program: cover property ($rose(busy_q));
  c_write_all: cover property (start_pg && pk_q == PG_WRITE_ALL);
endmodule

// ===== test/host_model.sv
// host side of the three-wire link: drives select, serial clock and data in
// assumes tasks are called at a falling edge of clk_i; sk period is 8 clk (400 ns)
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i, // system clock, pacing only
  input wire logic do_i, // resolved serial data out line
  output logic cs_o, // chip select
  output logic sk_o, // serial clock, still outside frames
  output logic di_o // serial data in
);
  // ----------------------------------------
  // bit and frame tasks
  // ----------------------------------------
  initial begin
    cs_o = 1'b0;
    sk_o = 1'b0;
    di_o = 1'b0;
  end

  task automatic sel(input logic v);
    cs_o = v;
  endtask

  // do is sampled 6 clk after the rise, well after it settles
  task automatic put_bit(input logic b, output logic r);
    di_o = b;
    repeat (2) @(negedge clk_i);
    sk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    sk_o = 1'b0;
    repeat (2) @(negedge clk_i);
    r = do_i;
  endtask

  // bits holds start, opcode, address, data; the first nb of them are sent
  task automatic frame(input logic [24:0] bits, input int nb, input int nz,
                       input int nrd, output logic [32:0] rd);
    logic r;
    cs_o = 1'b1;
    repeat (3) @(negedge clk_i);
    for (int k = 0; k < nz; k++) put_bit(1'b0, r);
    for (int k = 0; k < nb; k++) put_bit(bits[24 - k], r);
    rd = {32'h0, r};
    for (int k = 0; k < nrd; k++) begin
      put_bit(~di_o, r);
      rd = {rd[31:0], r};
    end
    cs_o = 1'b0;
    di_o = ~di_o;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// ===== test/tb_serial_eeprom_three_wire_port.sv
// self-checking bench for the serial eeprom port, 1 kbit build
// assumes host_model drives the pins; programming time shortened to PROG clk
`timescale 1ns/1ns
module tb_serial_eeprom_three_wire_port;
  localparam int PROG = 300;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic cs;
  wire logic sk;
  wire logic di;
  logic do_o;
  logic do_oe_o;
  logic busy_o;
  logic last_do = 1'b0;
  wire logic do_line;
  int busy_cnt = 0;
  int errors = 0;
  int n_checks = 0;

  // released line shows the inverse of its last driven level
  assign do_line = do_oe_o ? do_o : ~last_do;
  always @(posedge clk_i) if (do_oe_o) last_do <= do_o;
  always @(posedge clk_i) if (busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
  initial forever #25 clk_i = ~clk_i;

  // size and fifo depth stay at their defaults: 1 kbit array, 16-word read-ahead
  eeprom_serial_port #(.PROG_CYC(PROG)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cs_i(cs), .sk_i(sk), .di_i(di),
    .do_o(do_o), .do_oe_o(do_oe_o), .busy_o(busy_o));
  host_model h (.clk_i(clk_i), .do_i(do_line), .cs_o(cs), .sk_o(sk), .di_o(di));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [24:0] c(input logic [1:0] op, input logic [5:0] a,
                                    input logic [15:0] d);
    return {1'b1, op, a, d};
  endfunction

  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({32'h0, got}, {32'h0, exp});
  endtask

  task automatic results;
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // programming command, then status, refusal, ready and release checks
  task automatic prog(input logic [24:0] b, input int nb, input logic exp);
    logic r;
    logic [32:0] rd;
    int t;
    busy_cnt = 0;
    t = 0;
    h.frame(b, nb, 0, 0, rd);
    h.sel(1'b1);
    repeat (8) @(negedge clk_i);
    chk_bit(do_oe_o, exp);
    if (exp) begin
      chk_bit(do_line, 1'b0);
      h.sel(1'b0);
      repeat (6) @(negedge clk_i);
      chk_bit(do_oe_o, 1'b0);
      h.sel(1'b1);
      repeat (8) @(negedge clk_i);
      h.put_bit(1'b1, r);
      chk_bit(r, 1'b0);
      while (do_line !== 1'b1 && t < 2 * PROG) begin
        @(negedge clk_i);
        t++;
      end
      repeat (8) @(negedge clk_i);
      chk_word(33'(busy_cnt), 33'(PROG));
      chk_bit(do_line, 1'b1);
      h.put_bit(1'b1, r);
      chk_bit(do_oe_o, 1'b0);
    end
    h.sel(1'b0);
    repeat (6) @(negedge clk_i);
    chk_word(33'(busy_cnt), exp ? 33'(PROG) : 33'h0);
  endtask

  // two-word streaming read with dummy zero in front
  task automatic rd_chk(input logic [5:0] a, input int nz, input logic [31:0] exp);
    logic [32:0] rd;
    h.frame(c(2'h2, a, 16'h0), 9, nz, 32, rd);
    chk_word(rd, {1'b0, exp});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_locked;
    prog(c(2'h1, 6'h05, 16'h1234), 25, 1'b0);
  endtask

  task automatic t_write_read;
    logic [32:0] rd;
    h.frame(c(2'h0, 6'h30, 16'h0), 9, 0, 0, rd);
    prog(c(2'h1, 6'h05, 16'hA5C3), 25, 1'b1);
    prog(c(2'h1, 6'h06, 16'h0F0F), 25, 1'b1);
    rd_chk(6'h05, 0, 32'hA5C3_0F0F);
  endtask

  task automatic t_all_wrap;
    prog(c(2'h0, 6'h10, 16'h5A5A), 25, 1'b1);
    prog(c(2'h3, 6'h3F, 16'h0), 9, 1'b1);
    prog(c(2'h1, 6'h00, 16'h1357), 25, 1'b1);
    rd_chk(6'h3F, 3, 32'hFFFF_1357);
    rd_chk(6'h3D, 0, 32'h5A5A_5A5A);
  endtask

  task automatic t_erase_all_words_disable;
    logic [32:0] rd;
    prog(c(2'h0, 6'h20, 16'h0), 9, 1'b1);
    h.frame(c(2'h0, 6'h00, 16'h0), 9, 0, 0, rd);
    prog(c(2'h1, 6'h00, 16'h0000), 25, 1'b0);
    rd_chk(6'h00, 0, 32'hFFFF_FFFF);
  endtask

  initial begin
    #1000000;
    errors++;
    results();
  end

  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_bit(do_oe_o, 1'b0);
    t_locked();
    t_write_read();
    t_all_wrap();
    t_erase_all_words_disable();
    results();
  end
endmodule
